// ==== logic/sctl_map.svh ====
// Purpose: timing counts and field widths of the static ram controller
// Assumes: 125 MHz controller clock, 8 ns period
// Notes:   times in ns as printed, counts derived from them
`ifndef SCTL_MAP_SVH
`define SCTL_MAP_SVH

`define SCTL_CLK_PERIOD_NS      8
`define SCTL_ADDR_W             10
`define SCTL_WORDS              1024
// read cycle time of the slowest grade, ns
`define SCTL_READ_CYCLE_NS      650
// write pulse width, ns
`define SCTL_WRITE_PULSE_NS     200
// address set-up before write strobe, ns
`define SCTL_ADDR_SETUP_NS      20
// access time from chip select, ns
`define SCTL_ACCESS_NS          650
// deselect_before_standby_time, ns
`define SCTL_DESELECT_NS        0
// standby_recovery_time equals one read cycle
`define SCTL_RECOVERY_NS        `SCTL_READ_CYCLE_NS
`define SCTL_CEIL(t) (((t) + `SCTL_CLK_PERIOD_NS - 1) / `SCTL_CLK_PERIOD_NS)
`define SCTL_MIN1(n) (((n) < 1) ? 1 : (n))
`define SCTL_READ_CYC   `SCTL_MIN1(`SCTL_CEIL(`SCTL_READ_CYCLE_NS))
`define SCTL_WPULSE_CYC `SCTL_MIN1(`SCTL_CEIL(`SCTL_WRITE_PULSE_NS))
`define SCTL_SETUP_CYC  `SCTL_MIN1(`SCTL_CEIL(`SCTL_ADDR_SETUP_NS))
`define SCTL_ACCESS_CYC `SCTL_MIN1(`SCTL_CEIL(`SCTL_ACCESS_NS))
`define SCTL_DESEL_CYC  `SCTL_MIN1(`SCTL_CEIL(`SCTL_DESELECT_NS))
`define SCTL_RECOV_CYC  `SCTL_MIN1(`SCTL_CEIL(`SCTL_RECOVERY_NS))

`endif

// ==== logic/sctl_pkg.sv ====
// Purpose: types of the static ram controller
// Assumes: nothing
// Notes:   constants live in sctl_map.svh
`default_nettype none
package sctl_pkg;

  typedef enum logic [3:0]
  {
    SCTL_IDLE,
    SCTL_RD_ACCESS,
    SCTL_RD_HOLD,
    SCTL_WR_SETUP,
    SCTL_WR_PULSE,
    SCTL_WR_HOLD,
    SCTL_DESELECT,
    SCTL_STANDBY,
    SCTL_RECOVER
  } sctl_state_type;

  typedef logic [9:0] sctl_addr_type;

endpackage : sctl_pkg
`default_nettype wire

// ==== logic/sctl_timer.sv ====
// Purpose: down counter that times each phase of a memory cycle except SCTL_WR_HOLD
// Assumes: load and count never both needed in one cycle
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module sctl_timer #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         clkEn,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              done
);

  typedef struct packed
  {
    logic [W-1:0] cnt;
  } sctl_timer_state_type;

  sctl_timer_state_type timer_q;
  sctl_timer_state_type timer_d;

  always_comb
  begin
    timer_d = timer_q;
    if (load)
    begin
      timer_d.cnt = loadVal;
    end
    else if (timer_q.cnt != '0)
    begin
      timer_d.cnt = timer_q.cnt - W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_q <= '0;
    end
    else if (clkEn)
    begin
      timer_q <= timer_d;
    end
  end

  assign done = (timer_q.cnt == '0);

endmodule : sctl_timer
`default_nettype wire

// ==== logic/sctl_ctrl.sv ====
// Purpose: host controller driving a 1024x1 asynchronous static ram
// Assumes: one request at a time, inputs synchronous to ref_clk
// Notes:   pins are registered; data pin from memory is three-state
//
// What this block does
// RULE1: access the memory only while chip select is driven low
// RULE2: write strobe low writes the data bit, high reads the cell
// RULE3: chip select and write strobe stay low together through the pulse
// RULE4: data bit held steady until the write strobe rises
// RULE5: memory needs no refresh, so the controller issues none
// RULE6: no stored bit may change during standby
// RULE7: deselect before standby and keep chip select high throughout
// RULE8: wait one read cycle after standby before any access
// RULE9: memory holds 1024 single-bit words
// RULE10: memory output drives only while chip select is low
// RULE11: ten-bit address selects one cell, reads return last write
`timescale 1ns/1ps
`default_nettype none
`include "sctl_map.svh"
module sctl_ctrl #(
  parameter int AW = `SCTL_ADDR_W
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic                 clkEn,
  input  wire logic                 reqValid,
  input  wire logic                 reqWrite,
  input  wire sctl_pkg::sctl_addr_type reqAddr,
  input  wire logic                 reqData,
  output logic                      reqReady,
  output logic                      rspValid,
  output logic                      rspData,
  input  wire logic                 standbyReq,
  output logic                      standbyAck,
  output logic                      memPowerLow,
  output logic [AW-1:0]             memAddr,
  output logic                      memChipSel_n,
  output logic                      memWrite_n,
  output logic                      memDataIn,
  input  wire logic                 memDataOut
);
  import sctl_pkg::*;

  localparam int TW = 8;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed
  {
    sctl_state_type st;
    logic           ready;
    logic           rspV;
    logic           rspD;
    logic           sbAck;
    logic           pwrLow;
    logic [AW-1:0]  addr;
    logic           cs_n;
    logic           we_n;
    logic           din;
  } sctl_ctrl_state_type;

  sctl_ctrl_state_type ctl_q;
  sctl_ctrl_state_type ctl_d;
  logic                tmrLoad;
  logic [TW-1:0]       tmrVal;
  logic                tmrDone;

  sctl_timer #(
    .W(TW)
  ) u_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .done    (tmrDone)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    ctl_d   = ctl_q;
    tmrLoad = 1'b0;
    tmrVal  = '0;
    ctl_d.rspV = 1'b0;
    case (ctl_q.st)
      SCTL_IDLE:
      begin
        ctl_d.cs_n = 1'b1;
        ctl_d.we_n = 1'b1;
        if (standbyReq)
        begin
          // chip select already high; hold it the deselect time
          ctl_d.ready = 1'b0;
          ctl_d.st    = SCTL_DESELECT;  // see RULE7
          tmrLoad     = 1'b1;
          tmrVal      = TW'(`SCTL_DESEL_CYC - 1);
        end
        else if (reqValid && ctl_q.ready)
        begin
          ctl_d.ready = 1'b0;
          ctl_d.addr  = reqAddr;  // see RULE11
          ctl_d.din   = reqData;
          if (reqWrite)
          begin
            ctl_d.cs_n = 1'b0;
            ctl_d.st   = SCTL_WR_SETUP;
            tmrLoad    = 1'b1;
            tmrVal     = TW'(`SCTL_SETUP_CYC - 1);
          end
          else
          begin
            ctl_d.cs_n = 1'b0;  // see RULE1
            ctl_d.st   = SCTL_RD_ACCESS;  // see RULE2
            tmrLoad    = 1'b1;
            tmrVal     = TW'(`SCTL_ACCESS_CYC - 1);
          end
        end
      end
      SCTL_RD_ACCESS:
      begin
        if (tmrDone)
        begin
          ctl_d.rspV = 1'b1;
          ctl_d.rspD = memDataOut;
          ctl_d.cs_n = 1'b1;
          ctl_d.st   = SCTL_RD_HOLD;
          tmrLoad    = 1'b1;
          tmrVal     = TW'(`SCTL_READ_CYC - `SCTL_ACCESS_CYC);
        end
      end
      SCTL_WR_SETUP:
      begin
        if (tmrDone)
        begin
          ctl_d.we_n = 1'b0;  // see RULE3
          ctl_d.st   = SCTL_WR_PULSE;
          tmrLoad    = 1'b1;
          tmrVal     = TW'(`SCTL_WPULSE_CYC - 1);
        end
      end
      SCTL_WR_PULSE:
      begin
        if (tmrDone)
        begin
          // strobe rises first; address, data, select stay put
          ctl_d.we_n = 1'b1;  // see RULE4
          ctl_d.st   = SCTL_WR_HOLD;
        end
      end
      SCTL_WR_HOLD:
      begin
        ctl_d.cs_n = 1'b1;
        ctl_d.st   = SCTL_RD_HOLD;
        tmrLoad    = 1'b1;
        tmrVal     = TW'(`SCTL_READ_CYC - `SCTL_SETUP_CYC
                         - `SCTL_WPULSE_CYC);
      end
      SCTL_RD_HOLD:
      begin
        // pad the cycle out to a full read or write cycle time
        if (tmrDone)
        begin
          ctl_d.ready = 1'b1;
          ctl_d.st    = SCTL_IDLE;
        end
      end
      SCTL_DESELECT:
      begin
        if (tmrDone)
        begin
          ctl_d.pwrLow = 1'b1;
          ctl_d.sbAck  = 1'b1;
          ctl_d.st     = SCTL_STANDBY;
        end
      end
      SCTL_STANDBY:
      begin
        // pins stay quiet so no cell can be disturbed
        ctl_d.cs_n = 1'b1;  // see RULE6
        ctl_d.we_n = 1'b1;
        if (!standbyReq)
        begin
          ctl_d.pwrLow = 1'b0;
          ctl_d.st     = SCTL_RECOVER;
          tmrLoad      = 1'b1;
          tmrVal       = TW'(`SCTL_RECOV_CYC - 1);
        end
      end
      SCTL_RECOVER:
      begin
        if (tmrDone)
        begin
          ctl_d.sbAck = 1'b0;
          ctl_d.ready = 1'b1;  // see RULE8
          ctl_d.st    = SCTL_IDLE;
        end
      end
      default:
      begin
        ctl_d.st   = SCTL_IDLE;
        ctl_d.cs_n = 1'b1;
        ctl_d.we_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_q       <= '0;
      ctl_q.st    <= SCTL_IDLE;
      ctl_q.ready <= 1'b1;
      ctl_q.cs_n  <= 1'b1;
      ctl_q.we_n  <= 1'b1;
    end
    else if (clkEn)
    begin
      ctl_q <= ctl_d;
    end
  end

  assign reqReady     = ctl_q.ready;
  assign rspValid     = ctl_q.rspV;
  assign rspData      = ctl_q.rspD;
  assign standbyAck   = ctl_q.sbAck;
  assign memPowerLow  = ctl_q.pwrLow;
  assign memAddr      = ctl_q.addr;
  assign memChipSel_n = ctl_q.cs_n;
  assign memWrite_n   = ctl_q.we_n;
  assign memDataIn    = ctl_q.din;

endmodule : sctl_ctrl
`default_nettype wire

// ==== dv/sctl_sram_model.sv ====
// Purpose: behavioural 1024x1 static ram facing the controller
// Assumes: pins change only on controller clock edges
// Notes:   undriven output shows inverse of last driven bit
`timescale 1ns/1ps
`default_nettype none
module sctl_sram_model (
  input  wire logic                    pwrLow,
  input  wire sctl_pkg::sctl_addr_type addr,
  input  wire logic                    csN,
  input  wire logic                    weN,
  input  wire logic                    din,
  output logic                         dout
);
  logic mem [1024];
  logic lastBit = 1'b0;
  wire  drv = !csN && weN && !pwrLow;
  // bit taken as it stands when the strobe rises
  always @(posedge weN)
    if (!csN && !pwrLow) mem[addr] = din;
  always @*
    if (drv) lastBit = mem[addr];
  assign dout = drv ? mem[addr] : ~lastBit;
endmodule : sctl_sram_model
`default_nettype wire

// ==== dv/sctl_ctrl_monitor.sv ====
// Purpose: pin timing checks of the static ram controller
// Assumes: clkEn dropped only while idle
// Notes:   cycle counts follow the controller hand-over
`timescale 1ns/1ps
`default_nettype none
module sctl_ctrl_monitor #(
  parameter int AW = 10
) (
  input wire logic                    ref_clk,
  input wire logic                    nrst,
  input wire logic                    clkEn,
  input wire logic                    reqValid,
  input wire logic                    reqWrite,
  input wire sctl_pkg::sctl_addr_type reqAddr,
  input wire logic                    reqData,
  input wire logic                    reqReady,
  input wire logic                    rspValid,
  input wire logic                    rspData,
  input wire logic                    standbyReq,
  input wire logic                    standbyAck,
  input wire logic                    memPowerLow,
  input wire logic [AW-1:0]           memAddr,
  input wire logic                    memChipSel_n,
  input wire logic                    memWrite_n,
  input wire logic                    memDataIn,
  input wire logic                    memDataOut
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sel_write_a: assert property (
    memChipSel_n |-> memWrite_n) else $error("strobe while deselected");
  wr_setup_a: assert property (
    $fell(memWrite_n) |-> !$past(memChipSel_n, 3) && $stable(memAddr))
    else $error("write setup wrong");
  pulse_len_a: assert property (
    $fell(memWrite_n) |-> ##25 $rose(memWrite_n))
    else $error("write pulse length wrong");
  pulse_sel_a: assert property (
    $rose(memWrite_n) |-> !memChipSel_n) else $error("select left early");
  data_hold_a: assert property (
    !memWrite_n |-> $stable(memDataIn) && $stable(memAddr))
    else $error("data moved in pulse");
  rd_latency_a: assert property (
    clkEn && reqValid && reqReady && !reqWrite && !standbyReq
    |-> ##83 rspValid) else $error("read answer late");
  rd_data_a: assert property (
    rspValid |-> rspData == $past(memDataOut)) else $error("read bit wrong");
  stby_entry_a: assert property (
    $rose(memPowerLow) |-> $past(memChipSel_n, 2) && standbyAck)
    else $error("standby entered while selected");
  stby_quiet_a: assert property (
    memPowerLow |-> memChipSel_n && memWrite_n)
    else $error("access in standby");
  recover_a: assert property (
    $fell(memPowerLow) |-> ((memChipSel_n && !reqReady) throughout ##81 1)
    ##1 reqReady) else $error("recovery wrong");
endmodule : sctl_ctrl_monitor
bind sctl_ctrl sctl_ctrl_monitor #(.AW(AW)) mon (.ref_clk, .nrst, .clkEn,
  .reqValid, .reqWrite, .reqAddr, .reqData, .reqReady, .rspValid, .rspData,
  .standbyReq, .standbyAck, .memPowerLow, .memAddr, .memChipSel_n,
  .memWrite_n, .memDataIn, .memDataOut);
`default_nettype wire

// ==== dv/test_async_sram_1kx1_standby.sv ====
// Purpose: self-checking bench for the static ram controller
// Assumes: clkEn dropped only while idle
// Notes:   memory model stands on the far side
`timescale 1ns/1ps
`default_nettype none
`include "sctl_map.svh"
module test_async_sram_1kx1_standby;
  import sctl_pkg::*;
  logic ref_clk = 0, nrst = 0, clkEn = 1, reqValid = 0, reqWrite = 0;
  logic reqData = 0, standbyReq = 0, memDataOut;
  sctl_addr_type reqAddr = '0, memAddr;
  logic reqReady, rspValid, rspData, standbyAck, memPowerLow;
  logic memChipSel_n, memWrite_n, memDataIn;
  int   miscompares = 0, tests_run = 0, cyc = 0;
  sctl_addr_type at [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
  sctl_ctrl DUT (.ref_clk, .nrst, .clkEn, .reqValid, .reqWrite, .reqAddr,
    .reqData, .reqReady, .rspValid, .rspData, .standbyReq, .standbyAck,
    .memPowerLow, .memAddr, .memChipSel_n, .memWrite_n, .memDataIn,
    .memDataOut);
  sctl_sram_model mem (.pwrLow(memPowerLow), .addr(memAddr),
    .csN(memChipSel_n), .weN(memWrite_n), .din(memDataIn), .dout(memDataOut));
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2500)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one request; a read checks the returned bit
  task automatic req(input logic w, input sctl_addr_type a, input logic d);
    int n;
    @(negedge ref_clk);
    reqValid = 1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    @(negedge ref_clk);
    reqValid = 0;
    for (n = 0; !w && n < 100 && rspValid !== 1; n++) @(negedge ref_clk);
    if (!w) chk(16'(n), 16'(`SCTL_ACCESS_CYC));
    if (!w) chk(16'(rspData), 16'(d));
    for (n = 0; n < 100 && reqReady !== 1; n++) @(negedge ref_clk);
    chk(16'(reqReady), 16'h1);
  endtask : req
  task automatic t_rw;
    for (int i = 0; i < 4; i++) req(1, at[i], i[0]);
    req(1, at[0], 1);
    for (int i = 0; i < 4; i++) req(0, at[i], i == 0 || i[0]);
  endtask : t_rw
  task automatic t_stby;
    int n;
    @(negedge ref_clk);
    standbyReq = 1;
    repeat (3) @(negedge ref_clk);
    chk(16'({standbyAck, memPowerLow, memChipSel_n}), 16'h7);
    chk(16'(reqReady), 16'h0);
    reqValid = 1;
    reqWrite = 1;
    reqAddr = at[1];
    reqData = 0;
    repeat (20) @(negedge ref_clk);
    chk(16'({memChipSel_n, memWrite_n, memPowerLow}), 16'h7);
    reqValid = 0;
    standbyReq = 0;
    for (n = 0; n < 300 && reqReady !== 1; n++) @(negedge ref_clk);
    chk(16'(n), 16'(`SCTL_RECOV_CYC + 1));
    chk(16'({standbyAck, memPowerLow}), 16'h0);
    req(0, at[1], 1);
  endtask : t_stby
  // frozen clock enable: a request must not be taken
  task automatic t_freeze;
    @(negedge ref_clk);
    clkEn = 0;
    reqValid = 1;
    reqWrite = 1;
    reqAddr = at[2];
    reqData = 1;
    repeat (4) @(negedge ref_clk);
    chk(16'({reqReady, memChipSel_n, memWrite_n}), 16'h7);
    reqValid = 0;
    clkEn = 1;
    req(0, at[2], 0);
  endtask : t_freeze
  initial
  begin
    repeat (6) @(negedge ref_clk);
    chk(16'({reqReady, memChipSel_n, memWrite_n}), 16'h7);
    nrst = 1;
    t_rw();
    t_freeze();
    t_stby();
    summarize();
  end
endmodule : test_async_sram_1kx1_standby
`default_nettype wire
